// ---- rtl/cmd_status_pkg.sv ----
/*
  Types of the common command and status handler.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cmd_status_pkg;

  // ========================================================================
  // Sequencer states, Gray coded along idle, run, wait, answer
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_EXEC   = 3'b001,
    ST_HOLD   = 3'b011,
    ST_ANSWER = 3'b010,
    ST_TEST   = 3'b110
  } seq_state_t;

endpackage

// ---- rtl/cmd_status_regs.svh ----
/*
  Constants of the common command and status handler: command codes, status bit positions,
  reset values, memory depth and timing counts.
  Assumes inclusion by bare name from rtl/ files.
*/
`ifndef CMD_STATUS_REGS_SVH
`define CMD_STATUS_REGS_SVH

// ==========================================================================
// Command codes on the CMD_CODE port
`define CMD_CLEAR_STATUS   5'h01
`define CMD_SET_EVT_ENABLE 5'h02
`define CMD_QRY_EVT_ENABLE 5'h03
`define CMD_QRY_EVT_STATUS 5'h04
`define CMD_QRY_IDENT      5'h05
`define CMD_QRY_INDIV      5'h06
`define CMD_OP_COMPLETE    5'h07
`define CMD_QRY_OP_COMPL   5'h08
`define CMD_QRY_OPTIONS    5'h09
`define CMD_SET_POLL_EN    5'h0A
`define CMD_QRY_POLL_EN    5'h0B
`define CMD_SET_PON_CLEAR  5'h0C
`define CMD_QRY_PON_CLEAR  5'h0D
`define CMD_RECALL         5'h0E
`define CMD_DEVICE_RESET   5'h0F
`define CMD_SAVE           5'h10
`define CMD_SAVE_DEFAULTS  5'h11
`define CMD_SET_SRQ_EN     5'h12
`define CMD_QRY_SRQ_EN     5'h13
`define CMD_QRY_STB        5'h14
`define CMD_TRIGGER        5'h15
`define CMD_QRY_SELFTEST   5'h16
`define CMD_WAIT           5'h17
`define CMD_QRY_CURRENT    5'h18
`define CMD_QRY_POWER      5'h19
`define CMD_QRY_VOLTAGE    5'h1A

// ==========================================================================
// Status bit positions
`define EVT_BIT_OPC        0
`define EVT_BIT_QUERY_ERR  2
`define EVT_BIT_CMD_ERR    5
`define EVT_BIT_PWR_ON     7
`define STB_BIT_EAV        2
`define STB_BIT_ESB        5
`define STB_BIT_MSS        6

// ==========================================================================
// Values and sizes
`define ASCII_ONE          8'h31
`define ASCII_ZERO         8'h30
`define SETTING_LOCS       4
`define SETTING_W          32
`define FACTORY_SETTINGS   32'h0000_0000
`define OPTIONS_WORD       8'h00
`define IDENT_WORD         8'h5A
`define SELFTEST_NS        400
`define SELFTEST_CYCLES    (`SELFTEST_NS / 40)

`endif

// ---- rtl/common_command_status_handler.sv ----
/*
  Common command interpreter and status reporting for a programmable supply: status and
  enable registers, operation complete, wait, trigger, self-test, reset, save and recall.
  Assumes a parser upstream decodes each command of a string into CMD_CODE and CMD_ARG,
  one per strobe in order, and a host side reads RESP_DATA beats.
*/
// Notes on behaviour
// - Clear status empties event register, queue flag and pending operation-complete.
// - Event enable mask loads from argument and reads back on query.
// - Event register query returns present event register contents.
// - Option query returns the installed options word.
// - Individual status query returns the ist local message state.
// - After operation-complete command, event bit sets once operations finish.
// - Operation-complete query answers ASCII one only after operations finish.
// - Parallel poll enable mask loads from argument and reads back.
// - Power-on clear setting loads and reads back, but enable masks clear at reset whether it is 1 or 0.
// - Recall restores settings from the stored location.
// - Device reset forces settings to a fixed known state.
// - Save stores current settings at the given location.
// - Save-defaults stores factory settings at the given location.
// - Service request enable mask loads from argument with bit 6 cleared, and reads back.
// - Status byte query returns status byte with master summary bit.
// - Trigger command acts like a group execute trigger message.
// - Self-test query runs the test and answers pass or fail.
// - Wait command holds later commands until no operation is pending.
// - Commands of one string are executed one after another.
`timescale 1ns/1ps
`include "cmd_status_regs.svh"

module common_command_status_handler (
  input  wire logic                   CLK,
  input  wire logic                   RESET,
  input  wire logic                   CMD_VALID,
  input  wire logic [4:0]             CMD_CODE,
  input  wire logic [15:0]            CMD_ARG,
  output logic                        CMD_READY,
  output logic                        RESP_VALID,
  output logic [15:0]                 RESP_DATA,
  input  wire logic                   RESP_READY,
  input  wire logic                   OPS_PENDING,
  input  wire logic                   SELFTEST_FAIL,
  input  wire logic                   QUERY_ERROR,
  input  wire logic                   CMD_ERROR,
  input  wire logic [15:0]            MEAS_CURRENT,
  input  wire logic [15:0]            MEAS_POWER,
  input  wire logic [15:0]            MEAS_VOLTAGE,
  input  wire logic [`SETTING_W-1:0]  SETTINGS_IN,
  output logic [`SETTING_W-1:0]       SETTINGS_OUT,
  output logic                        SETTINGS_LOAD,
  output logic                        TRIGGER_PULSE,
  output logic                        SELFTEST_START,
  output logic                        SRQ,
  output logic                        IST
);

  // ==========================================================================
  // State
  cmd_status_pkg::seq_state_t state_q, state_d;
  logic [7:0]             evt_q;
  logic [7:0]             evt_en_q;
  logic [7:0]             srq_en_q;
  logic [7:0]             poll_en_q;
  logic                   pon_clear_q;
  logic                   pon_done_q;
  logic                   opc_armed_q;
  logic [4:0]             cmd_q;
  logic [15:0]            arg_q;
  logic [7:0]             test_cnt_q;
  logic [`SETTING_W-1:0]  mem_rd;

  // ==========================================================================
  // Status summaries
  wire        esb_sum   = |(evt_q & evt_en_q);
  wire        eav_sum   = RESP_VALID;
  wire [7:0]  stb_raw   = {1'b0, 1'b0, esb_sum, 2'b00, eav_sum, 2'b00};
  wire        mss       = |(stb_raw & srq_en_q);
  wire [7:0]  stb_full  = stb_raw | ({7'h00, mss} << `STB_BIT_MSS);
  wire        ist_now   = |(stb_full & poll_en_q);
  wire        take      = CMD_VALID && CMD_READY;

  // Stored-settings traffic
  wire        mem_we    = (state_q == cmd_status_pkg::ST_EXEC)
                          && (cmd_q == `CMD_SAVE || cmd_q == `CMD_SAVE_DEFAULTS);
  wire [`SETTING_W-1:0] mem_wd = (cmd_q == `CMD_SAVE_DEFAULTS) ? `FACTORY_SETTINGS
                                                               : SETTINGS_IN;

  setting_store u_store (
    .clk     (CLK),
    .wr_en   (mem_we),
    .loc     (arg_q[1:0]),
    .wr_data (mem_wd),
    .rd_data (mem_rd)
  );

  // ==========================================================================
  // Functions
  function automatic logic is_query(input logic [4:0] c);
    is_query = (c == `CMD_QRY_EVT_ENABLE) || (c == `CMD_QRY_EVT_STATUS) ||
               (c == `CMD_QRY_IDENT) || (c == `CMD_QRY_INDIV) ||
               (c == `CMD_QRY_OP_COMPL) || (c == `CMD_QRY_OPTIONS) ||
               (c == `CMD_QRY_POLL_EN) || (c == `CMD_QRY_PON_CLEAR) ||
               (c == `CMD_QRY_SRQ_EN) || (c == `CMD_QRY_STB) ||
               (c == `CMD_QRY_CURRENT) || (c == `CMD_QRY_POWER) ||
               (c == `CMD_QRY_VOLTAGE);
  endfunction

  function automatic logic [15:0] byte_word(input logic [7:0] b);
    byte_word = {8'h00, b};
  endfunction

  // Answer word for a query
  logic [15:0] answer;
  always_comb begin
    case (cmd_q)
      `CMD_QRY_EVT_ENABLE: answer = byte_word(evt_en_q);
      `CMD_QRY_EVT_STATUS: answer = byte_word(evt_q);
      `CMD_QRY_IDENT:      answer = byte_word(`IDENT_WORD);
      `CMD_QRY_INDIV:      answer = byte_word({7'h00, ist_now});
      `CMD_QRY_OP_COMPL:   answer = byte_word(`ASCII_ONE);
      `CMD_QRY_OPTIONS:    answer = byte_word(`OPTIONS_WORD);
      `CMD_QRY_POLL_EN:    answer = byte_word(poll_en_q);
      `CMD_QRY_PON_CLEAR:  answer = byte_word({7'h00, pon_clear_q});
      `CMD_QRY_SRQ_EN:     answer = byte_word(srq_en_q);
      `CMD_QRY_STB:        answer = byte_word(stb_full);
      `CMD_QRY_CURRENT:    answer = MEAS_CURRENT;
      `CMD_QRY_POWER:      answer = MEAS_POWER;
      `CMD_QRY_VOLTAGE:    answer = MEAS_VOLTAGE;
      default:             answer = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Sequencer: one command at a time, in arrival order
  always_comb begin
    state_d = state_q;
    case (state_q)
      cmd_status_pkg::ST_IDLE: begin
        if (take) begin
          state_d = cmd_status_pkg::ST_EXEC;
        end
      end
      cmd_status_pkg::ST_EXEC: begin
        if (cmd_q == `CMD_WAIT || cmd_q == `CMD_QRY_OP_COMPL) begin
          state_d = cmd_status_pkg::ST_HOLD;
        end else if (cmd_q == `CMD_QRY_SELFTEST) begin
          state_d = cmd_status_pkg::ST_TEST;
        end else if (is_query(cmd_q)) begin
          state_d = cmd_status_pkg::ST_ANSWER;
        end else begin
          state_d = cmd_status_pkg::ST_IDLE;
        end
      end
      cmd_status_pkg::ST_HOLD: begin
        if (!OPS_PENDING) begin
          state_d = (cmd_q == `CMD_WAIT) ? cmd_status_pkg::ST_IDLE
                                         : cmd_status_pkg::ST_ANSWER;
        end
      end
      cmd_status_pkg::ST_TEST: begin
        if (test_cnt_q == 8'h00) begin
          state_d = cmd_status_pkg::ST_ANSWER;
        end
      end
      cmd_status_pkg::ST_ANSWER: begin
        if (RESP_VALID && RESP_READY) begin
          state_d = cmd_status_pkg::ST_IDLE;
        end
      end
      default: state_d = cmd_status_pkg::ST_IDLE;
    endcase
  end

  wire entering_answer = (state_q != cmd_status_pkg::ST_ANSWER)
                         && (state_d == cmd_status_pkg::ST_ANSWER);
  wire in_exec         = (state_q == cmd_status_pkg::ST_EXEC);
  wire clear_status    = in_exec && (cmd_q == `CMD_CLEAR_STATUS);
  wire dev_reset       = in_exec && (cmd_q == `CMD_DEVICE_RESET);
  wire opc_done        = opc_armed_q && !OPS_PENDING;
  wire [7:0] evt_set   = ({7'h00, opc_done} << `EVT_BIT_OPC)
                         | ({7'h00, QUERY_ERROR} << `EVT_BIT_QUERY_ERR)
                         | ({7'h00, CMD_ERROR} << `EVT_BIT_CMD_ERR);
  wire answer_taken    = (state_q == cmd_status_pkg::ST_ANSWER) && RESP_VALID && RESP_READY;
  wire [7:0] evt_clr   = clear_status ? 8'hFF : 8'h00;
  wire [7:0] evt_rd_clr = (answer_taken && cmd_q == `CMD_QRY_EVT_STATUS) ? 8'hFF : 8'h00;

  // Strobe decodes of the execute cycle
  wire do_opc_cmd      = in_exec && (cmd_q == `CMD_OP_COMPLETE);
  wire do_recall       = in_exec && (cmd_q == `CMD_RECALL);
  wire do_trigger      = in_exec && (cmd_q == `CMD_TRIGGER);
  wire do_selftest     = in_exec && (cmd_q == `CMD_QRY_SELFTEST);

  // ==========================================================================
  // Sequencer state
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= cmd_status_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Command capture at the taking edge, held for the whole command
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cmd_q <= 5'h00;
      arg_q <= 16'h0000;
    end else if (take) begin
      cmd_q <= CMD_CODE;
      arg_q <= CMD_ARG;
    end
  end

  // Event register: hardware set wins over software clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      evt_q <= 8'h80;
    end else begin
      evt_q <= (evt_q & ~(evt_clr | evt_rd_clr)) | evt_set;
    end
  end

  // Pending operation-complete request
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      opc_armed_q <= 1'b0;
    end else if (do_opc_cmd) begin
      opc_armed_q <= 1'b1;
    end else if (clear_status || opc_done) begin
      opc_armed_q <= 1'b0;
    end
  end

  // Power-on clear setting
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pon_clear_q <= 1'b1;
    end else if (in_exec && cmd_q == `CMD_SET_PON_CLEAR) begin
      pon_clear_q <= arg_q[0];
    end
  end

  // Enable masks, cleared by RESET whatever the power-on clear setting
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      evt_en_q    <= 8'h00;
      srq_en_q    <= 8'h00;
      poll_en_q   <= 8'h00;
      pon_done_q  <= 1'b0;
    end else begin
      pon_done_q <= 1'b1;
      if (!pon_done_q && pon_clear_q) begin
        evt_en_q  <= 8'h00;
        srq_en_q  <= 8'h00;
        poll_en_q <= 8'h00;
      end else if (in_exec) begin
        case (cmd_q)
          `CMD_SET_EVT_ENABLE: evt_en_q    <= arg_q[7:0];
          `CMD_SET_SRQ_EN:     srq_en_q    <= arg_q[7:0] & 8'hBF;
          `CMD_SET_POLL_EN:    poll_en_q   <= arg_q[7:0];
          default:             poll_en_q   <= poll_en_q;
        endcase
      end
    end
  end

  // Self-test timer
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      test_cnt_q <= 8'h00;
    end else if (do_selftest) begin
      test_cnt_q <= 8'(`SELFTEST_CYCLES - 1);
    end else if (test_cnt_q != 8'h00) begin
      test_cnt_q <= test_cnt_q - 8'h01;
    end
  end

  // Answer valid: rises with the answer, falls at the edge that takes it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RESP_VALID <= 1'b0;
    end else if (entering_answer) begin
      RESP_VALID <= 1'b1;
    end else if (RESP_READY) begin
      RESP_VALID <= 1'b0;
    end
  end

  // Answer word, loaded once per query and held while it waits
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RESP_DATA <= 16'h0000;
    end else if (entering_answer) begin
      RESP_DATA <= (cmd_q == `CMD_QRY_SELFTEST) ? {15'h0000, SELFTEST_FAIL}
                                                : answer;
    end
  end

  // Settings word to apply, with its load strobe
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SETTINGS_OUT  <= `FACTORY_SETTINGS;
      SETTINGS_LOAD <= 1'b0;
    end else begin
      SETTINGS_LOAD <= dev_reset || do_recall;
      if (dev_reset) begin
        SETTINGS_OUT <= `FACTORY_SETTINGS;
      end else if (do_recall) begin
        SETTINGS_OUT <= mem_rd;
      end
    end
  end

  // One-cycle strobes to the trigger and self-test logic
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      TRIGGER_PULSE  <= 1'b0;
      SELFTEST_START <= 1'b0;
    end else begin
      TRIGGER_PULSE  <= do_trigger;
      SELFTEST_START <= do_selftest;
    end
  end

  // Service request and ist pins, a cycle behind the summaries
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SRQ <= 1'b0;
      IST <= 1'b0;
    end else begin
      SRQ <= mss;
      IST <= ist_now;
    end
  end

  // Ready only while the sequencer returns to idle with nothing taken
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CMD_READY <= 1'b0;
    end else begin
      CMD_READY <= (state_d == cmd_status_pkg::ST_IDLE) && !take;
    end
  end

endmodule

// ---- rtl/setting_store.sv ----
/*
  Small memory of saved setting words with one write and one read port.
  Assumes the caller keeps the location inside the depth.
*/
`timescale 1ns/1ps
`include "cmd_status_regs.svh"

module setting_store (
  input  wire logic                    clk,
  input  wire logic                    wr_en,
  input  wire logic [1:0]              loc,
  input  wire logic [`SETTING_W-1:0]   wr_data,
  output wire logic [`SETTING_W-1:0]   rd_data
);

  logic [`SETTING_W-1:0] mem [0:`SETTING_LOCS-1];

  // ==========================================================================
  // Storage, contents undefined until first written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[loc] <= wr_data;
    end
  end

  assign rd_data = mem[loc];

endmodule

// ---- tb/cmd_handler_props.sv ----
/*
  Port checker for the common command and status handler.
  Assumes one CLK domain with asynchronous active-high RESET; bound below.
*/
`timescale 1ns/1ps
`include "cmd_status_regs.svh"

module cmd_handler_props (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CMD_VALID,
  input  wire logic [4:0]  CMD_CODE,
  input  wire logic [15:0] CMD_ARG,
  input  wire logic        CMD_READY,
  input  wire logic        RESP_VALID,
  input  wire logic [15:0] RESP_DATA,
  input  wire logic        RESP_READY,
  input  wire logic        OPS_PENDING,
  input  wire logic        SETTINGS_LOAD,
  input  wire logic        TRIGGER_PULSE,
  input  wire logic        SELFTEST_START,
  input  wire logic        SRQ,
  input  wire logic        IST
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // ==========================================================================
  // Last taken code and a mirror of the event enable mask
  logic [4:0] last_q;
  logic [7:0] ese_q;
  wire        take = CMD_VALID && CMD_READY;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      last_q <= 5'h00;
      ese_q  <= 8'h00;
    end else if (take) begin
      last_q <= CMD_CODE;
      if (CMD_CODE == `CMD_SET_EVT_ENABLE) ese_q <= CMD_ARG[7:0];
    end
  end

  // ==========================================================================
  // Handshake, strobes and answers
  a_resp_stands: assert property (RESP_VALID && !RESP_READY |=> RESP_VALID && $stable(RESP_DATA))
    else $error("answer dropped or changed before taken");
  a_busy_refuses: assert property (RESP_VALID |-> !CMD_READY)
    else $error("command accepted while answer waits");
  a_trig_pulse: assert property (take && CMD_CODE == `CMD_TRIGGER |-> ##2 TRIGGER_PULSE)
    else $error("trigger strobe missing");
  a_recall_load: assert property (take && CMD_CODE == `CMD_RECALL |-> ##2 SETTINGS_LOAD)
    else $error("recall did not load settings");
  a_test_start: assert property (take && CMD_CODE == `CMD_QRY_SELFTEST |-> ##2 SELFTEST_START)
    else $error("self-test not started");
  a_wait_holds: assert property (take && CMD_CODE == `CMD_WAIT ##1 OPS_PENDING [*4] |-> !CMD_READY)
    else $error("wait released while operations pend");
  a_ese_read: assert property ($rose(RESP_VALID) && last_q == `CMD_QRY_EVT_ENABLE
    |-> RESP_DATA == {8'h00, ese_q}) else $error("event enable readback wrong");
  a_stb_mss: assert property ($rose(RESP_VALID) && last_q == `CMD_QRY_STB
    |-> RESP_DATA[`STB_BIT_MSS] == SRQ) else $error("summary bit differs from SRQ");
  a_ist_read: assert property ($rose(RESP_VALID) && last_q == `CMD_QRY_INDIV
    |-> RESP_DATA[0] == IST) else $error("ist answer differs from IST");
  a_opc_one: assert property ($rose(RESP_VALID) && last_q == `CMD_QRY_OP_COMPL
    |-> RESP_DATA == 16'h0031 && !OPS_PENDING) else $error("early or wrong op answer");
endmodule

bind common_command_status_handler cmd_handler_props u_props (
  .CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_ARG(CMD_ARG),
  .CMD_READY(CMD_READY), .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA),
  .RESP_READY(RESP_READY), .OPS_PENDING(OPS_PENDING), .SETTINGS_LOAD(SETTINGS_LOAD),
  .TRIGGER_PULSE(TRIGGER_PULSE), .SELFTEST_START(SELFTEST_START), .SRQ(SRQ), .IST(IST));

// ---- tb/host_ctrl_model.sv ----
/*
  Behavioural remote host: offers decoded commands one at a time and takes answers.
  Assumes its tasks are called from the bench; changes pins only at falling edges.
*/
`timescale 1ns/1ps

module host_ctrl_model (
  input  wire logic        clk,
  input  wire logic        cmd_ready,
  input  wire logic        resp_valid,
  input  wire logic [15:0] resp_data,
  output logic             cmd_valid,
  output logic [4:0]       cmd_code,
  output logic [15:0]      cmd_arg,
  output logic             resp_ready
);
  logic hung = 1'b0;

  // ==========================================================================
  // Idle pins at time zero
  initial begin
    cmd_valid  = 1'b0;
    cmd_code   = 5'h00;
    cmd_arg    = 16'h0000;
    resp_ready = 1'b0;
  end

  // One command per offer, held until the edge that takes it, in order
  task automatic send(input logic [4:0] c, input logic [15:0] a);
    int n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_arg   = a;
    while (!cmd_ready && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) hung = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code  = ~c;
    cmd_arg   = ~a;
  endtask

  // Waits for an answer and takes it at one edge
  task automatic recv(output logic [15:0] d);
    int n = 0;
    while (!resp_valid && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) hung = 1'b1;
    d = resp_data;
    resp_ready = 1'b1;
    @(negedge clk);
    resp_ready = 1'b0;
  endtask
endmodule

// ---- tb/tb_common_command_status_handler.sv ----
/*
  Self-checking bench for the common command and status handler.
  Assumes the host model drives the command side; other inputs change at falling edges.
*/
`timescale 1ns/1ps
`include "cmd_status_regs.svh"

module tb_common_command_status_handler;
  typedef struct packed {
    logic [4:0]  c;
    logic [15:0] a;
    logic        q;
    logic [15:0] e;
  } row_t;

  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        OPS_PENDING = 1'b0;
  logic        SELFTEST_FAIL = 1'b0;
  logic        QUERY_ERROR = 1'b0;
  logic        CMD_ERROR = 1'b0;
  logic [15:0] MEAS_CURRENT = 16'h0A11;
  logic [15:0] MEAS_POWER = 16'h0B22;
  logic [15:0] MEAS_VOLTAGE = 16'h0C33;
  logic [31:0] SETTINGS_IN = 32'h1234ABCD;
  logic        CMD_VALID, CMD_READY, RESP_VALID, RESP_READY;
  logic [4:0]  CMD_CODE;
  logic [15:0] CMD_ARG, RESP_DATA, d;
  logic [31:0] SETTINGS_OUT;
  int          num_errors = 0;
  int          n_compared = 0;
  row_t        rows [15] = '{
    '{`CMD_QRY_EVT_STATUS, 16'h0000, 1'b1, 16'h0080}, '{`CMD_QRY_EVT_STATUS, 16'h0000, 1'b1, 16'h0000},
    '{`CMD_SET_EVT_ENABLE, 16'h00A5, 1'b0, 16'h0000}, '{`CMD_QRY_EVT_ENABLE, 16'h0000, 1'b1, 16'h00A5},
    '{`CMD_SET_POLL_EN, 16'h005A, 1'b0, 16'h0000}, '{`CMD_QRY_POLL_EN, 16'h0000, 1'b1, 16'h005A},
    '{`CMD_SET_SRQ_EN, 16'h00FF, 1'b0, 16'h0000}, '{`CMD_QRY_SRQ_EN, 16'h0000, 1'b1, 16'h00BF},
    '{`CMD_QRY_OPTIONS, 16'h0000, 1'b1, {8'h00, `OPTIONS_WORD}},
    '{`CMD_QRY_CURRENT, 16'h0000, 1'b1, 16'h0A11}, '{`CMD_QRY_POWER, 16'h0000, 1'b1, 16'h0B22},
    '{`CMD_QRY_VOLTAGE, 16'h0000, 1'b1, 16'h0C33}, '{`CMD_QRY_PON_CLEAR, 16'h0000, 1'b1, 16'h0001},
    '{`CMD_SET_PON_CLEAR, 16'h0000, 1'b0, 16'h0000}, '{`CMD_QRY_PON_CLEAR, 16'h0000, 1'b1, 16'h0000}};

  // ==========================================================================
  // Design, host model and clock
  common_command_status_handler dut (
    .CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_ARG(CMD_ARG),
    .CMD_READY(CMD_READY), .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA),
    .RESP_READY(RESP_READY), .OPS_PENDING(OPS_PENDING), .SELFTEST_FAIL(SELFTEST_FAIL),
    .QUERY_ERROR(QUERY_ERROR), .CMD_ERROR(CMD_ERROR), .MEAS_CURRENT(MEAS_CURRENT),
    .MEAS_POWER(MEAS_POWER), .MEAS_VOLTAGE(MEAS_VOLTAGE), .SETTINGS_IN(SETTINGS_IN),
    .SETTINGS_OUT(SETTINGS_OUT), .SETTINGS_LOAD(), .TRIGGER_PULSE(), .SELFTEST_START(),
    .SRQ(), .IST());
  host_ctrl_model host (
    .clk(CLK), .cmd_ready(CMD_READY), .resp_valid(RESP_VALID), .resp_data(RESP_DATA),
    .cmd_valid(CMD_VALID), .cmd_code(CMD_CODE), .cmd_arg(CMD_ARG), .resp_ready(RESP_READY));
  initial begin
    forever #20 CLK = ~CLK;
  end

  // ==========================================================================
  // Comparison, command helpers and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang_check;
    if (host.hung) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic ask(input logic [4:0] c, input logic [15:0] a);
    host.send(c, a);
    host.recv(d);
    hang_check();
  endtask
  task automatic cmd(input logic [4:0] c, input logic [15:0] a);
    host.send(c, a);
    hang_check();
    repeat (3) @(negedge CLK);
  endtask
  task automatic errs;
    QUERY_ERROR = 1'b1;
    CMD_ERROR = 1'b1;
    @(negedge CLK);
    QUERY_ERROR = 1'b0;
    CMD_ERROR = 1'b0;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    give_verdict();
  end

  // ==========================================================================
  // Table of plain cases, then hand-written cases
  initial begin
    repeat (8) @(negedge CLK);
    RESET = 1'b0;
    repeat (2) @(negedge CLK);
    foreach (rows[i]) begin
      if (rows[i].q) begin
        ask(rows[i].c, rows[i].a);
        check(d, rows[i].e);
      end else cmd(rows[i].c, rows[i].a);
    end
    cmd(`CMD_SET_PON_CLEAR, 16'h0001);
    ask(`CMD_QRY_IDENT, 16'h0000);
    errs();
    ask(`CMD_QRY_STB, 16'h0000);
    check(d & 16'hFFFB, 16'h0060);
    check(dut.SRQ, 1'b1);
    ask(`CMD_QRY_INDIV, 16'h0000);
    check(d, 16'h0001);
    check(dut.IST, 1'b1);
    cmd(`CMD_CLEAR_STATUS, 16'h0000);
    check(dut.SRQ, 1'b0);
    ask(`CMD_QRY_EVT_STATUS, 16'h0000);
    check(d, 16'h0000);
    errs();
    ask(`CMD_QRY_EVT_STATUS, 16'h0000);
    check(d, 16'h0024);
    OPS_PENDING = 1'b1;
    cmd(`CMD_OP_COMPLETE, 16'h0000);
    host.send(`CMD_QRY_OP_COMPL, 16'h0000);
    repeat (6) @(negedge CLK);
    check(RESP_VALID, 1'b0);
    OPS_PENDING = 1'b0;
    host.recv(d);
    check(d, 16'h0031);
    ask(`CMD_QRY_EVT_STATUS, 16'h0000);
    check(d, 16'h0001);
    OPS_PENDING = 1'b1;
    host.send(`CMD_WAIT, 16'h0000);
    repeat (6) @(negedge CLK);
    check(CMD_READY, 1'b0);
    OPS_PENDING = 1'b0;
    cmd(`CMD_TRIGGER, 16'h0000);
    cmd(`CMD_SAVE, 16'h0002);
    cmd(`CMD_SAVE_DEFAULTS, 16'h0001);
    cmd(`CMD_RECALL, 16'h0002);
    check(SETTINGS_OUT, 32'h1234ABCD);
    cmd(`CMD_RECALL, 16'h0001);
    check(SETTINGS_OUT, `FACTORY_SETTINGS);
    cmd(`CMD_RECALL, 16'h0002);
    cmd(`CMD_DEVICE_RESET, 16'h0000);
    check(SETTINGS_OUT, `FACTORY_SETTINGS);
    SELFTEST_FAIL = 1'b1;
    ask(`CMD_QRY_SELFTEST, 16'h0000);
    check(d, 16'h0001);
    SELFTEST_FAIL = 1'b0;
    ask(`CMD_QRY_SELFTEST, 16'h0000);
    check(d, 16'h0000);
    RESET = 1'b1;
    repeat (2) @(negedge CLK);
    RESET = 1'b0;
    repeat (2) @(negedge CLK);
    ask(`CMD_QRY_EVT_STATUS, 16'h0000);
    check(d, 16'h0080);
    ask(`CMD_QRY_EVT_ENABLE, 16'h0000);
    check(d, 16'h0000);
    give_verdict();
  end
endmodule
